/* hw/baud_gen.v */
// One channel's prescaler and fractional baud generator.
// Assumes divisor inputs come from registers on the same clock.
`timescale 1ns/1ns
`include "quad_uart_map.vh"
module baud_gen (
	input wire clk, // Oscillator clock
	input wire sys_rst, // Asynchronous reset, active high
	input wire soft_rst, // Synchronous restart pulse
	input wire [15:0] div_int, // Integer part of divisor
	input wire [3:0] div_frac, // Fraction in sixteenths
	input wire prescale4, // Divide input clock by 4
	input wire eight_x, // Eight samples per bit
	output reg sample_tick_q, // Sampling clock pulse
	output reg bit_tick_q // Bit time pulse
);
	reg [1:0] pre_q;
	reg [16:0] cnt_q;
	reg [3:0] acc_q;
	reg [3:0] smp_q;
	wire pre_tick = ~prescale4 | (pre_q == `PRESCALE_LAST);
	wire [16:0] div_eff = (div_int == 16'h0000) ? 17'h00001 :
		{1'b0, div_int};
	wire [4:0] acc_sum = {1'b0, acc_q} + {1'b0, div_frac};
	wire [3:0] smp_last = eight_x ? `SAMPLES_8X_LAST : `SAMPLES_16X_LAST;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pre_q <= 2'h0;
			cnt_q <= 17'h00000;
			acc_q <= 4'h0;
			smp_q <= 4'h0;
			sample_tick_q <= 1'b0;
			bit_tick_q <= 1'b0;
		end else if (soft_rst) begin
			pre_q <= 2'h0;
			cnt_q <= 17'h00000;
			acc_q <= 4'h0;
			smp_q <= 4'h0;
			sample_tick_q <= 1'b0;
			bit_tick_q <= 1'b0;
		end else begin
			sample_tick_q <= 1'b0;
			bit_tick_q <= 1'b0;
			pre_q <= (prescale4 && !pre_tick) ? pre_q + 2'h1 : 2'h0;
			if (pre_tick) begin
				if (cnt_q == 17'h00000) begin
					sample_tick_q <= 1'b1;
					acc_q <= acc_sum[3:0];
					cnt_q <= div_eff - 17'h00001 + {16'h0000, acc_sum[4]};
					if (smp_q >= smp_last) begin
						smp_q <= 4'h0;
						bit_tick_q <= 1'b1;
					end else begin
						smp_q <= smp_q + 4'h1;
					end
				end else begin
					cnt_q <= cnt_q - 17'h00001;
				end
			end
		end
	end
endmodule

/* hw/quad_uart_front.v */
// Host front end of a four-channel UART: bus decode, channel registers,
// broadcast writes, interrupt levels and per-channel baud generators.
// Assumes host pins are asynchronous and hold address and data steady
// for at least three clocks around each strobe edge; line status inputs
// come from transmit and receive logic on the same clock.
`timescale 1ns/1ns
`include "quad_uart_map.vh"

// How it works
// - Writing the global reset register restores every channel register default.
// - Bus cycles count only while chip select is low.
// - Top two address lines low: next two lines pick channel 0 to 3.
// - Broadcast bit set: any channel write lands in all four channels.
// - Tx, no FIFO, no half-duplex: high while holding register full.
// - Tx, no FIFO, half-duplex: high until whole transmitter empty.
// - Tx FIFO: high above trigger, low below or empty.
// - Rx: low on one byte or FIFO above trigger, else high.
// - One clock drives all baud generators and the other logic.
// - Per-channel prescaler divides by 1 or 4, from modem control bit 7.
// - Baud generator divides by 1 to under 65536 in sixteenths.
// - Reset gives divisor one: low byte one, high and fraction zero.
// - Low and high bytes form integer; fraction has four bits.
// - Sampling clock paces transmit shifting and receive sampling.
// - Eight-times sampling doubles rate; odd fraction jitters bit time.
// - A bit lasts sixteen samples, or eight in eight-times mode.
module quad_uart_front (
	input wire clk, // Oscillator clock for all logic
	input wire sys_rst, // Asynchronous reset, active high
	input wire cs_n, // Chip select pin, active low
	input wire wr_n, // Write strobe pin, active low
	input wire rd_n, // Read strobe pin, active low
	input wire [7:0] addr, // Address pins
	input wire [7:0] wdata, // Write data pins
	output wire [7:0] rdata_q, // Read data word
	output wire rdata_valid_q, // Read data word is present
	input wire rdata_ready, // Reader takes the word
	input wire [3:0] thr_full, // Holding register has a byte
	input wire [3:0] tx_all_empty, // Holding and shift registers empty
	input wire [3:0] tx_fifo_empty, // Transmit FIFO empty
	input wire [3:0] tx_above_trig, // Transmit FIFO above trigger level
	input wire [3:0] rx_ready, // Receiver holds a byte
	input wire [3:0] rx_above_trig, // Receive FIFO above trigger level
	output reg [3:0] tx_irq_q, // Transmit interrupt level per channel
	output reg [3:0] rx_irq_q, // Receive interrupt level per channel
	output reg [3:0] fifo_en_q, // FIFO enable per channel
	output reg soft_rst_q, // Channel logic restart pulse
	output wire [3:0] sample_tick_q, // Sampling clock per channel
	output wire [3:0] bit_tick_q // Bit time pulse per channel
);
	reg [18:0] pin_meta_q;
	reg [18:0] pin_sync_q;
	reg wr_prev_q;
	reg rd_prev_q;
	reg [7:0] div_low_q [0:3];
	reg [7:0] div_high_q [0:3];
	reg [3:0] div_frac_q [0:3];
	reg [7:0] fifo_ctrl_q [0:3];
	reg [7:0] modem_ctrl_q [0:3];
	reg [3:0] half_duplex_q;
	reg bcast_q;
	reg [3:0] eight_x_q;
	reg pend_q;
	reg [7:0] pend_data_q;
	reg [7:0] rd_word;
	reg [3:0] wr_mask;
	wire pend_ready;
	integer i;

	wire s_cs_n = pin_sync_q[18];
	wire s_wr_n = pin_sync_q[17];
	wire s_rd_n = pin_sync_q[16];
	wire [7:0] s_addr = pin_sync_q[15:8];
	wire [7:0] s_wdata = pin_sync_q[7:0];
	wire wr_take = wr_prev_q & ~s_wr_n & ~s_cs_n;
	wire rd_take = rd_prev_q & ~s_rd_n & ~s_cs_n;
	wire is_cfg = s_addr[7];
	wire ch_ok = ~s_addr[7] & ~s_addr[6];
	wire [1:0] ch = s_addr[5:4];
	wire [3:0] off = s_addr[3:0];

	// Transmit interrupt level for one channel
	function tx_level;
		input fifo_en;
		input hd;
		input held;
		input all_empty;
		input fifo_empty;
		input above;
		begin
			if (!fifo_en) begin
				tx_level = hd ? ~all_empty : held;
			end else begin
				tx_level = above & ~(hd ? all_empty : fifo_empty);
			end
		end
	endfunction

	// Receive interrupt level: low means data to unload
	function rx_level;
		input fifo_en;
		input ready;
		input above;
		begin
			rx_level = fifo_en ? ~above : ~ready;
		end
	endfunction

	// Pin synchroniser; the first stage feeds only the second
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta_q <= 19'h70000;
			pin_sync_q <= 19'h70000;
			wr_prev_q <= 1'b1;
			rd_prev_q <= 1'b1;
		end else begin
			pin_meta_q <= {cs_n, wr_n, rd_n, addr, wdata};
			pin_sync_q <= pin_meta_q;
			wr_prev_q <= s_wr_n;
			rd_prev_q <= s_rd_n;
		end
	end

	// Channels reached by a write
	always @* begin
		wr_mask = 4'h0;
		if (wr_take && ch_ok) begin
			if (bcast_q) begin
				wr_mask = 4'hf;
			end else begin
				wr_mask[ch] = 1'b1;
			end
		end
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (i = 0; i < 4; i = i + 1) begin
				div_low_q[i] <= `DIV_LOW_RST;
				div_high_q[i] <= `DIV_HIGH_RST;
				div_frac_q[i] <= `DIV_FRAC_RST;
				fifo_ctrl_q[i] <= `FIFO_CTRL_RST;
				modem_ctrl_q[i] <= `MODEM_CTRL_RST;
			end
			half_duplex_q <= {4{`HALF_DUPLEX_RST}};
			bcast_q <= `BROADCAST_RST;
			eight_x_q <= `EIGHT_X_RST;
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= 1'b0;
			if (wr_take && s_addr == `CFG_GLOBAL_RESET) begin
				for (i = 0; i < 4; i = i + 1) begin
					div_low_q[i] <= `DIV_LOW_RST;
					div_high_q[i] <= `DIV_HIGH_RST;
					div_frac_q[i] <= `DIV_FRAC_RST;
					fifo_ctrl_q[i] <= `FIFO_CTRL_RST;
					modem_ctrl_q[i] <= `MODEM_CTRL_RST;
				end
				half_duplex_q <= {4{`HALF_DUPLEX_RST}};
				soft_rst_q <= 1'b1;
			end else begin
				if (wr_take && s_addr == `CFG_BROADCAST) begin
					bcast_q <= s_wdata[`BCAST_BIT];
				end else if (wr_take && s_addr == `CFG_EIGHT_X) begin
					eight_x_q <= s_wdata[3:0];
				end
				for (i = 0; i < 4; i = i + 1) begin
					if (wr_mask[i]) begin
						if (off == `CH_DIV_LOW) begin
							div_low_q[i] <= s_wdata;
						end else if (off == `CH_DIV_HIGH) begin
							div_high_q[i] <= s_wdata;
						end else if (off == `CH_DIV_FRAC) begin
							div_frac_q[i] <= s_wdata[3:0];
						end else if (off == `CH_FIFO_CTRL) begin
							fifo_ctrl_q[i] <= s_wdata;
						end else if (off == `CH_MODEM_CTRL) begin
							modem_ctrl_q[i] <= s_wdata;
						end else if (off == `CH_HALF_DUPLEX) begin
							half_duplex_q[i] <= s_wdata[`HALF_DUPLEX_BIT];
						end
					end
				end
			end
		end
	end

	// Read data word for the addressed register; unmapped reads give zero
	always @* begin
		rd_word = 8'h00;
		if (is_cfg) begin
			if (s_addr == `CFG_BROADCAST) begin
				rd_word = {7'h00, bcast_q};
			end else if (s_addr == `CFG_EIGHT_X) begin
				rd_word = {4'h0, eight_x_q};
			end else if (s_addr == `CFG_IRQ_STATE) begin
				rd_word = {rx_irq_q, tx_irq_q};
			end
		end else if (ch_ok) begin
			if (off == `CH_DIV_LOW) begin
				rd_word = div_low_q[ch];
			end else if (off == `CH_DIV_HIGH) begin
				rd_word = div_high_q[ch];
			end else if (off == `CH_DIV_FRAC) begin
				rd_word = {4'h0, div_frac_q[ch]};
			end else if (off == `CH_FIFO_CTRL) begin
				rd_word = fifo_ctrl_q[ch];
			end else if (off == `CH_MODEM_CTRL) begin
				rd_word = modem_ctrl_q[ch];
			end else if (off == `CH_HALF_DUPLEX) begin
				rd_word = {7'h00, half_duplex_q[ch]};
			end
		end
	end

	// One read waits here until the buffer takes it; reads meanwhile drop
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pend_q <= 1'b0;
			pend_data_q <= 8'h00;
		end else if (!pend_q) begin
			if (rd_take) begin
				pend_q <= 1'b1;
				pend_data_q <= rd_word;
			end
		end else if (pend_ready) begin
			pend_q <= 1'b0;
		end
	end

	skid_buffer2 u_rd_buf (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(pend_q),
		.in_ready(pend_ready),
		.in_data(pend_data_q),
		.out_valid_q(rdata_valid_q),
		.out_ready(rdata_ready),
		.out_data_q(rdata_q)
	);

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_irq_q <= 4'h0;
			rx_irq_q <= 4'hf;
			fifo_en_q <= 4'h0;
		end else begin
			for (i = 0; i < 4; i = i + 1) begin
				fifo_en_q[i] <= fifo_ctrl_q[i][`FIFO_EN_BIT];
				tx_irq_q[i] <= tx_level(fifo_ctrl_q[i][`FIFO_EN_BIT],
					half_duplex_q[i], thr_full[i], tx_all_empty[i],
					tx_fifo_empty[i], tx_above_trig[i]);
				rx_irq_q[i] <= rx_level(fifo_ctrl_q[i][`FIFO_EN_BIT],
					rx_ready[i], rx_above_trig[i]);
			end
		end
	end

	// Every generator runs on the one oscillator clock
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : chan
			baud_gen u_baud (
				.clk(clk),
				.sys_rst(sys_rst),
				.soft_rst(soft_rst_q),
				.div_int({div_high_q[g], div_low_q[g]}),
				.div_frac(div_frac_q[g]),
				.prescale4(modem_ctrl_q[g][`PRESCALE_BIT]),
				.eight_x(eight_x_q[g]),
				.sample_tick_q(sample_tick_q[g]),
				.bit_tick_q(bit_tick_q[g])
			);
		end
	endgenerate
endmodule

/* hw/skid_buffer2.v */
// Two-entry buffer with valid and ready on both sides; outputs from flops.
// Assumes a single clock shared by producer and consumer.
`timescale 1ns/1ns
module skid_buffer2 (
	input wire clk, // System clock
	input wire sys_rst, // Asynchronous reset, active high
	input wire in_valid, // Producer has a word
	output wire in_ready, // Buffer can take a word
	input wire [7:0] in_data, // Word from producer
	output reg out_valid_q, // Buffer holds a word for consumer
	input wire out_ready, // Consumer takes the word
	output reg [7:0] out_data_q // Word to consumer
);
	reg skid_valid_q;
	reg [7:0] skid_data_q;
	wire push = in_valid & in_ready;
	wire pop = out_valid_q & out_ready;

	assign in_ready = ~skid_valid_q;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_valid_q <= 1'b0;
			out_data_q <= 8'h00;
			skid_valid_q <= 1'b0;
			skid_data_q <= 8'h00;
		end else if (pop) begin
			if (skid_valid_q) begin
				out_data_q <= skid_data_q;
				skid_valid_q <= 1'b0;
			end else if (push) begin
				out_data_q <= in_data;
			end else begin
				out_valid_q <= 1'b0;
			end
		end else if (push) begin
			if (!out_valid_q) begin
				out_data_q <= in_data;
				out_valid_q <= 1'b1;
			end else begin
				skid_data_q <= in_data;
				skid_valid_q <= 1'b1;
			end
		end
	end
endmodule

/* pkg/quad_uart_map.vh */
// Register map, field positions, reset values and counts of the quad UART
// front end. Assumes inclusion by bare name from the design files.
`ifndef QUAD_UART_MAP_VH
`define QUAD_UART_MAP_VH

// Channel space (top two address lines low): offset in address bits 3:0
`define CH_DIV_LOW 4'h0
`define CH_DIV_HIGH 4'h1
`define CH_DIV_FRAC 4'h2
`define CH_FIFO_CTRL 4'h3
`define CH_MODEM_CTRL 4'h4
`define CH_HALF_DUPLEX 4'h5

// Configuration space (top address line high): full address
`define CFG_GLOBAL_RESET 8'h80
`define CFG_BROADCAST 8'h81
`define CFG_EIGHT_X 8'h82
`define CFG_IRQ_STATE 8'h83

// Reset values
`define DIV_LOW_RST 8'h01
`define DIV_HIGH_RST 8'h00
`define DIV_FRAC_RST 4'h0
`define FIFO_CTRL_RST 8'h00
`define MODEM_CTRL_RST 8'h00
`define HALF_DUPLEX_RST 1'b0
`define BROADCAST_RST 1'b0
`define EIGHT_X_RST 4'h0

// Field positions
`define BCAST_BIT 0
`define FIFO_EN_BIT 0
`define PRESCALE_BIT 7
`define HALF_DUPLEX_BIT 0

// Counts
`define PRESCALE_LAST 2'h3
`define SAMPLES_16X_LAST 4'hf
`define SAMPLES_8X_LAST 4'h7

`endif

/* test/host_bus_model.sv */
// Host processor model driving the front end's bus pins.
// Assumes the front end answers reads through its read buffer.
`timescale 1ns/1ns
module host_bus_model (
	input wire clk, // Clock
	output reg cs_n, // Select
	output reg wr_n, // Write
	output reg rd_n, // Read
	output reg [7:0] addr, // Address
	output reg [7:0] wdata, // Data
	output reg rdata_ready, // Take word
	input wire [7:0] rdata_q, // Word
	input wire rdata_valid_q // Present
);
	initial begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		rdata_ready = 1'b0;
	end
	// One strobe; sel low keeps the chip deselected
	task automatic acc(input [7:0] a, input [7:0] d, input w, input sel);
		@(posedge clk);
		cs_n <= !sel;
		addr <= a;
		wdata <= d;
		repeat (3) @(posedge clk);
		wr_n <= !w;
		rd_n <= w;
		repeat (4) @(posedge clk);
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (3) @(posedge clk);
		cs_n <= 1'b1;
		// Released pins do not keep the old value
		addr <= ~a;
		wdata <= ~d;
	endtask
	task automatic pop(output [7:0] d);
		integer n;
		rdata_ready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n = n + 1;
		end while (rdata_valid_q !== 1'b1 && n < 12);
		d = rdata_valid_q === 1'b1 ? rdata_q : 8'hxx;
		rdata_ready <= 1'b0;
		@(posedge clk);
	endtask
	// Divisor in sixteenths, rounded, split into three registers
	task automatic baud(input [7:0] base, input integer fclk, input integer r);
		integer d16;
		d16 = (2 * fclk / r + 1) / 2;
		acc(base + 8'h01, d16[19:12], 1'b1, 1'b1);
		acc(base, d16[11:4], 1'b1, 1'b1);
		acc(base + 8'h02, {4'h0, d16[3:0]}, 1'b1, 1'b1);
	endtask
endmodule

/* test/quad_uart_front_test.sv */
// Self-checking bench of the quad UART front end.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ns
module quad_uart_front_test;
	// Divisor 3 and 5/16: 53 clocks per 16 samples
	localparam [15:0] PER = 16 * 3 + 5;
	reg clk;
	reg sys_rst;
	reg [3:0] thr_full, tx_all_empty, tx_fifo_empty, tx_above_trig;
	reg [3:0] rx_ready, rx_above_trig;
	wire cs_n, wr_n, rd_n, rdata_ready, rdata_valid_q, soft_rst_q;
	wire [7:0] addr, wdata, rdata_q;
	wire [3:0] tx_irq_q, rx_irq_q, fifo_en_q, sample_tick_q, bit_tick_q;
	integer mismatches;
	integer samples_checked;
	host_bus_model host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
		.addr(addr), .wdata(wdata), .rdata_ready(rdata_ready),
		.rdata_q(rdata_q), .rdata_valid_q(rdata_valid_q));
	quad_uart_front dut (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
		.wr_n(wr_n), .rd_n(rd_n), .addr(addr), .wdata(wdata),
		.rdata_q(rdata_q), .rdata_valid_q(rdata_valid_q),
		.rdata_ready(rdata_ready), .thr_full(thr_full),
		.tx_all_empty(tx_all_empty), .tx_fifo_empty(tx_fifo_empty),
		.tx_above_trig(tx_above_trig), .rx_ready(rx_ready),
		.rx_above_trig(rx_above_trig), .tx_irq_q(tx_irq_q),
		.rx_irq_q(rx_irq_q), .fifo_en_q(fifo_en_q), .soft_rst_q(soft_rst_q),
		.sample_tick_q(sample_tick_q), .bit_tick_q(bit_tick_q));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task stop_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check_word(input [15:0] got, input [15:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_level(input got, input exp);
		check_word({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic wr(input [7:0] a, input [7:0] d);
		host.acc(a, d, 1'b1, 1'b1);
	endtask
	task automatic rd_exp(input [7:0] a, input [7:0] e);
		reg [7:0] d;
		host.acc(a, 8'h00, 1'b0, 1'b1);
		host.pop(d);
		check_word({8'h00, d}, {8'h00, e});
	endtask
	// Clocks per 16 sample ticks, or sample ticks per bit
	task automatic span(input integer ch, input bits, output integer n);
		integer k;
		n = 0;
		k = 0;
		do @(posedge clk);
		while ((bits ? bit_tick_q[ch] : sample_tick_q[ch]) !== 1'b1);
		do begin
			@(posedge clk);
			n = n + 1;
			if (sample_tick_q[ch] === 1'b1)
				k = k + 1;
		end while (bits ? bit_tick_q[ch] !== 1'b1 : k < 16);
		if (bits)
			n = k;
	endtask
	initial begin
		#100000;
		mismatches = mismatches + 1;
		stop_test;
	end
	initial begin : main
		integer c, m, p, n;
		reg [7:0] d;
		reg [3:0] pat [0:3];
		reg tx_e;
		mismatches = 0;
		samples_checked = 0;
		// Status patterns: held, all empty, FIFO empty, above trigger
		pat[0] = 4'h6;
		pat[1] = 4'h8;
		pat[2] = 4'h2;
		pat[3] = 4'h9;
		sys_rst = 1'b1;
		{thr_full, tx_above_trig, rx_ready, rx_above_trig} = 16'h0000;
		{tx_all_empty, tx_fifo_empty} = 8'hff;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		for (c = 0; c < 4; c = c + 1) begin
			rd_exp({1'b0, c[2:0], 4'h0}, 8'h01);
			rd_exp({1'b0, c[2:0], 4'h1}, 8'h00);
			rd_exp({1'b0, c[2:0], 4'h2}, 8'h00);
			wr({1'b0, c[2:0], 4'h0}, 8'h10 + c[7:0]);
		end
		for (c = 0; c < 4; c = c + 1)
			rd_exp({1'b0, c[2:0], 4'h0}, 8'h10 + c[7:0]);
		wr(8'h02, 8'hff);
		rd_exp(8'h02, 8'h0f);
		host.acc(8'h00, 8'h99, 1'b1, 1'b0);
		host.acc(8'h00, 8'h00, 1'b0, 1'b0);
		check_level(rdata_valid_q, 1'b0);
		rd_exp(8'h00, 8'h10);
		rd_exp(8'h0e, 8'h00);
		rd_exp(8'h40, 8'h00);
		$display("test registers done");
		wr(8'h81, 8'h01);
		wr(8'h11, 8'ha5);
		wr(8'h81, 8'h00);
		for (c = 0; c < 4; c = c + 1)
			rd_exp({1'b0, c[2:0], 4'h1}, 8'ha5);
		wr(8'h80, 8'h00);
		for (c = 0; c < 4; c = c + 1) begin
			rd_exp({1'b0, c[2:0], 4'h0}, 8'h01);
			rd_exp({1'b0, c[2:0], 4'h1}, 8'h00);
		end
		$display("test broadcast and reset done");
		for (m = 0; m < 4; m = m + 1) begin
			wr(8'h13, {7'h00, m[0]});
			wr(8'h15, {7'h00, m[1]});
			for (p = 0; p < 4; p = p + 1) begin
				@(posedge clk);
				{thr_full[1], tx_all_empty[1], tx_fifo_empty[1],
					tx_above_trig[1]} <= pat[p];
				rx_ready[1] <= p[0];
				rx_above_trig[1] <= p[1];
				repeat (2) @(posedge clk);
				if (m[0])
					tx_e = pat[p][0] && !(m[1] ? pat[p][2] : pat[p][1]);
				else
					tx_e = m[1] ? !pat[p][2] : pat[p][3];
				check_level(tx_irq_q[1], tx_e);
				check_level(rx_irq_q[1], m[0] ? !p[1] : !p[0]);
				check_level(fifo_en_q[1], m[0]);
			end
		end
		$display("test interrupt levels done");
		for (c = 0; c < 4; c = c + 1)
			wr({1'b0, c[2:0], 4'h0}, 8'h20 + c[7:0]);
		for (c = 0; c < 4; c = c + 1)
			host.acc({1'b0, c[2:0], 4'h0}, 8'h00, 1'b0, 1'b1);
		for (c = 0; c < 3; c = c + 1) begin
			host.pop(d);
			check_word({8'h00, d}, 16'h0020 + c[15:0]);
		end
		check_level(rdata_valid_q, 1'b0);
		$display("test read buffer done");
		host.baud(8'h20, 250000000, 4717000);
		rd_exp(8'h22, 8'h05);
		span(2, 1'b0, n);
		span(2, 1'b0, n);
		check_word(n[15:0], PER);
		span(2, 1'b1, n);
		check_word(n[15:0], 16'd16);
		wr(8'h82, 8'h04);
		span(2, 1'b1, n);
		span(2, 1'b1, n);
		check_word(n[15:0], 16'd8);
		wr(8'h24, 8'h80);
		span(2, 1'b0, n);
		span(2, 1'b0, n);
		check_word(n[15:0], {PER[13:0], 2'b00});
		$display("test baud generator done");
		stop_test;
	end
endmodule
bind quad_uart_front quad_uart_monitor mon (.clk(clk), .sys_rst(sys_rst),
	.cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr), .rdata_q(rdata_q),
	.rdata_valid_q(rdata_valid_q), .rdata_ready(rdata_ready),
	.thr_full(thr_full), .tx_all_empty(tx_all_empty),
	.tx_fifo_empty(tx_fifo_empty), .tx_above_trig(tx_above_trig),
	.rx_ready(rx_ready), .rx_above_trig(rx_above_trig),
	.tx_irq_q(tx_irq_q), .rx_irq_q(rx_irq_q), .fifo_en_q(fifo_en_q),
	.soft_rst_q(soft_rst_q), .sample_tick_q(sample_tick_q),
	.bit_tick_q(bit_tick_q));

/* test/quad_uart_monitor.sv */
// Checker of the quad UART front end, on its ports only.
// Assumes a bind from the bench top; level checks watch channel 1.
`timescale 1ns/1ns
module quad_uart_monitor (
	input wire clk, // Clock
	input wire sys_rst, // Reset
	input wire cs_n, // Select
	input wire wr_n, // Write
	input wire rd_n, // Read
	input wire [7:0] addr, // Address
	input wire [7:0] rdata_q, // Word
	input wire rdata_valid_q, // Present
	input wire rdata_ready, // Taken
	input wire [3:0] thr_full, // Held
	input wire [3:0] tx_all_empty, // Tx empty
	input wire [3:0] tx_fifo_empty, // FIFO empty
	input wire [3:0] tx_above_trig, // Tx trig
	input wire [3:0] rx_ready, // Rx byte
	input wire [3:0] rx_above_trig, // Rx trig
	input wire [3:0] tx_irq_q, // Tx level
	input wire [3:0] rx_irq_q, // Rx level
	input wire [3:0] fifo_en_q, // FIFO on
	input wire soft_rst_q, // Restart
	input wire [3:0] sample_tick_q, // Samples
	input wire [3:0] bit_tick_q // Bits
);
	reg [1:0] up_q;
	reg [4:0] smp_q;
	reg sure_q;
	wire up = up_q == 2'h3;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Sample ticks of channel 0 since its last bit tick
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			up_q <= 2'h0;
			smp_q <= 5'h00;
			sure_q <= 1'b0;
		end else begin
			if (!up)
				up_q <= up_q + 2'h1;
			if (bit_tick_q[0] || soft_rst_q)
				smp_q <= 5'h00;
			else if (sample_tick_q[0])
				smp_q <= smp_q + 5'h01;
			if (soft_rst_q)
				sure_q <= 1'b0;
			else if (bit_tick_q[0])
				sure_q <= 1'b1;
		end
	end
	sequence reset_write_s;
		$fell(wr_n) && !cs_n && addr == 8'h80;
	endsequence
	sequence read_start_s;
		$fell(rd_n) && !cs_n && !rdata_valid_q;
	endsequence
	soft_reset_a:
		assert property (reset_write_s |-> ##[2:6] soft_rst_q ##1 !soft_rst_q)
		else $error("no single restart pulse");
	read_answer_a:
		assert property (read_start_s |-> ##[3:7] rdata_valid_q)
		else $error("read not answered");
	ignored_read_a:
		assert property ($fell(rd_n) && cs_n && !rdata_valid_q |=>
			!rdata_valid_q [*8])
		else $error("deselected read answered");
	word_hold_a:
		assert property (rdata_valid_q && !rdata_ready |=>
			rdata_valid_q && $stable(rdata_q))
		else $error("read word lost");
	// The mode copy lags the status inputs by one clock, like the level, so it is read a cycle later
	tx_held_a:
		assert property (up && thr_full[1] ##1 !fifo_en_q[1] |->
			tx_irq_q[1])
		else $error("tx level low with byte held");
	tx_empty_a:
		assert property (up && tx_all_empty[1] ##1 !fifo_en_q[1] |->
			!tx_irq_q[1])
		else $error("tx level high when empty");
	tx_trig_a:
		assert property (up ##1 fifo_en_q[1] &&
			(!$past(tx_above_trig[1]) || (!$past(tx_all_empty[1]) &&
			!$past(tx_fifo_empty[1]))) |->
			tx_irq_q[1] == $past(tx_above_trig[1]))
		else $error("tx level wrong in FIFO mode");
	rx_byte_a:
		assert property (up ##1 !fifo_en_q[1] |->
			rx_irq_q[1] == !$past(rx_ready[1]))
		else $error("rx level wrong without FIFO");
	rx_trig_a:
		assert property (up ##1 fifo_en_q[1] |->
			rx_irq_q[1] == !$past(rx_above_trig[1]))
		else $error("rx level wrong in FIFO mode");
	bit_length_a:
		assert property (sure_q && bit_tick_q[0] |-> sample_tick_q[0] &&
			(smp_q == 5'h0f || smp_q == 5'h07))
		else $error("bit length not 16 or 8 samples");
endmodule
